// file: core/muldiv_unit.sv
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module muldiv_unit (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp
);

   muldiv_core_if core_if ();

   muldiv_engine #(
      .CNT_W (5)
   ) u_engine (
      .mclk  (mclk),
      .rst_n (rst_n),
      .core  (core_if)
   );

   logic                  acc;
   logic                  wr_pend_q;
   logic                  rd_pend_q;
   logic [7:0]            addr_q;
   logic                  is_opnd;
   logic                  is_stat;
   logic [2:0]            idx;
   logic                  busy;
   logic                  wr_ok;
   logic                  err_set;
   logic                  err_clr;
   logic                  err_q;
   logic                  ovf_q;
   logic [7:0]            opnd_q [muldiv_pkg::OPND_NUM];
   logic [7:0]            res_byte [muldiv_pkg::OPND_NUM];
   logic [5:0]            res_en;
   logic [7:0]            stat_val;
   logic [31:0]           rd_val;
   logic [31:0]           hrdata_q;
   muldiv_pkg::seq_e      seq_q;
   muldiv_pkg::seq_e      seq_d;
   logic                  start;
   muldiv_pkg::op_e       op;
   logic [47:0]           opnd_flat;

   // Bus slave: writes take no wait state, reads one
   assign acc = hsel && htrans[1] && hready;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
      end else begin
         wr_pend_q <= acc && hwrite;
         rd_pend_q <= acc && !hwrite;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         addr_q <= muldiv_pkg::OFS_OPND0;
      end else if (acc) begin
         addr_q <= haddr[7:0];
      end
   end

   assign hreadyout = !rd_pend_q;
   assign hresp     = muldiv_pkg::HRESP_OKAY;
   assign hrdata    = hrdata_q;

   assign is_opnd = (addr_q[1:0] == 2'h0) && (addr_q <= muldiv_pkg::OFS_OPND_LAST);
   assign is_stat = (addr_q == muldiv_pkg::OFS_STATUS);
   assign idx     = addr_q[4:2];
   assign busy    = core_if.busy;
   assign wr_ok   = wr_pend_q && is_opnd && !busy;

   // Write order tracking
   always_comb begin
      seq_d = seq_q;
      start = 1'b0;
      op    = muldiv_pkg::OP_DIV32;
      if (wr_ok) begin
         seq_d = (idx == muldiv_pkg::IDX_R0) ? muldiv_pkg::SEQ_W0
                                             : muldiv_pkg::SEQ_IDLE;
         case (seq_q)
            muldiv_pkg::SEQ_W0: begin
               if (idx == muldiv_pkg::IDX_R1) begin
                  seq_d = muldiv_pkg::SEQ_W01;
               end else if (idx == muldiv_pkg::IDX_R4) begin
                  seq_d = muldiv_pkg::SEQ_W04;
               end
            end
            muldiv_pkg::SEQ_W01: begin
               if (idx == muldiv_pkg::IDX_R2) begin
                  seq_d = muldiv_pkg::SEQ_W012;
               end else if (idx == muldiv_pkg::IDX_R4) begin
                  seq_d = muldiv_pkg::SEQ_W014;
               end
            end
            muldiv_pkg::SEQ_W04: begin
               if (idx == muldiv_pkg::IDX_R1) begin
                  seq_d = muldiv_pkg::SEQ_W041;
               end
            end
            muldiv_pkg::SEQ_W012: begin
               if (idx == muldiv_pkg::IDX_R3) begin
                  seq_d = muldiv_pkg::SEQ_W0123;
               end
            end
            muldiv_pkg::SEQ_W0123: begin
               if (idx == muldiv_pkg::IDX_R4) begin
                  seq_d = muldiv_pkg::SEQ_W01234;
               end
            end
            muldiv_pkg::SEQ_W01234: begin
               if (idx == muldiv_pkg::IDX_R5) begin
                  start = 1'b1;
                  op    = muldiv_pkg::OP_DIV32;
               end
            end
            muldiv_pkg::SEQ_W014: begin
               if (idx == muldiv_pkg::IDX_R5) begin
                  start = 1'b1;
                  op    = muldiv_pkg::OP_DIV16;
               end
            end
            muldiv_pkg::SEQ_W041: begin
               if (idx == muldiv_pkg::IDX_R5) begin
                  start = 1'b1;
                  op    = muldiv_pkg::OP_MUL;
               end
            end
            default: ;
         endcase
      end
   end

   // Reads and non-operand traffic leave the order untouched
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         seq_q <= muldiv_pkg::SEQ_IDLE;
      end else begin
         seq_q <= seq_d;
      end
   end

   assign core_if.start    = start;
   assign core_if.op       = op;
   assign core_if.dividend = {opnd_q[3], opnd_q[2], opnd_q[1], opnd_q[0]};
   assign core_if.divisor  = {hwdata[7:0], opnd_q[4]};

   // Result bytes per register
   always_comb begin
      res_byte[0] = core_if.quot[7:0];
      res_byte[1] = core_if.quot[15:8];
      res_byte[2] = core_if.quot[23:16];
      res_byte[3] = core_if.quot[31:24];
      res_byte[4] = core_if.rem[7:0];
      res_byte[5] = core_if.rem[15:8];
      res_en      = '0;
      if (core_if.done) begin
         case (core_if.run_op)
            muldiv_pkg::OP_DIV32: res_en = muldiv_pkg::RES_EN_DIV32;
            muldiv_pkg::OP_DIV16: res_en = muldiv_pkg::RES_EN_DIV16;
            muldiv_pkg::OP_MUL:   res_en = muldiv_pkg::RES_EN_MUL;
            default:              res_en = '0;
         endcase
      end
   end

   for (genvar i = 0; i < muldiv_pkg::OPND_NUM; i++) begin : g_opnd
      always_ff @(posedge mclk) begin
         if (!rst_n) begin
            opnd_q[i] <= muldiv_pkg::OPND_RST;
         end else if (res_en[i]) begin
            opnd_q[i] <= res_byte[i];
         end else if (wr_ok && idx == 3'(i)) begin
            opnd_q[i] <= hwdata[7:0];
         end
      end
      assign opnd_flat[8*i +: 8] = opnd_q[i];
   end

   // Access error flag; set wins over clear
   assign err_set = (wr_pend_q || rd_pend_q) && is_opnd && busy;
   assign err_clr = rd_pend_q && is_stat && !busy;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         err_q <= muldiv_pkg::STATUS_RST[muldiv_pkg::ERR_BIT];
      end else if (err_set) begin
         err_q <= 1'b1;
      end else if (err_clr) begin
         err_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ovf_q <= muldiv_pkg::STATUS_RST[muldiv_pkg::OVF_BIT];
      end else if (core_if.done) begin
         ovf_q <= core_if.ovf;
      end
   end

   always_comb begin
      stat_val                      = '0;
      stat_val[muldiv_pkg::ERR_BIT] = err_q;
      stat_val[muldiv_pkg::OVF_BIT] = ovf_q;
      rd_val                        = '0;
      if (is_opnd) begin
         rd_val = {24'h00_0000, opnd_q[idx]};
      end else if (is_stat) begin
         rd_val = {24'h00_0000, stat_val};
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hrdata_q <= muldiv_pkg::RDATA_RST;
      end else if (rd_pend_q) begin
         hrdata_q <= rd_val;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_stat_read;
      rd_pend_q && is_stat;
   endsequence

   AST_STATUS_LOW_ZERO:
   assert property (s_stat_read |=> hrdata[5:0] == 6'h00)
      else $error("status low bits not zero");
   AST_START_ON_R5:
   assert property (start |-> wr_pend_q && idx == muldiv_pkg::IDX_R5 && !busy
                    ##1 busy)
      else $error("start not tied to a register 5 write");
   AST_READ_KEEPS_ORDER:
   assert property (rd_pend_q |=> seq_q == $past(seq_q))
      else $error("read disturbed write order");
   AST_READ_KEEPS_DATA:
   assert property ((rd_pend_q && !core_if.done) |=> $stable(opnd_flat))
      else $error("read changed a result register");
   AST_ERR_ON_BUSY:
   assert property ((busy && (wr_pend_q || rd_pend_q) && is_opnd) |=> err_q [*2])
      else $error("busy access did not raise error flag");
   AST_ERR_CLEAR:
   assert property ((s_stat_read and (!busy && err_q)) |=> !err_q && hrdata[7])
      else $error("status read did not clear error flag");
   AST_OVF_REFRESH:
   assert property (core_if.done |=> ovf_q == $past(core_if.ovf) && !busy)
      else $error("overflow not refreshed at completion");
   AST_DIV32_PLACE:
   assert property ((core_if.done && core_if.run_op == muldiv_pkg::OP_DIV32)
                    |=> opnd_flat == {$past(core_if.rem), $past(core_if.quot)})
      else $error("32/16 results misplaced");
   AST_DIV16_PLACE:
   assert property ((core_if.done && core_if.run_op == muldiv_pkg::OP_DIV16)
                    |=> opnd_flat[15:0] == $past(core_if.quot[15:0])
                        && opnd_flat[47:32] == $past(core_if.rem))
      else $error("16/16 results misplaced");
   AST_MUL_PLACE:
   assert property ((core_if.done && core_if.run_op == muldiv_pkg::OP_MUL)
                    |=> opnd_flat[31:0] == $past(core_if.quot))
      else $error("product misplaced");
   AST_BAD_ORDER_DROP:
   assert property ((wr_ok && seq_q == muldiv_pkg::SEQ_IDLE && idx != muldiv_pkg::IDX_R0)
                    |=> seq_q == muldiv_pkg::SEQ_IDLE)
      else $error("stray write started an order");

endmodule // muldiv_unit
`default_nettype wire

// file: common/muldiv_pkg.sv
package muldiv_pkg;

   // Register map, one aligned word each
   localparam logic [7:0]  OFS_OPND0     = 8'h00;
   localparam logic [7:0]  OFS_OPND_LAST = 8'h14;
   localparam logic [7:0]  OFS_STATUS    = 8'h18;

   // Operand/result register indices
   localparam logic [2:0]  IDX_R0 = 3'h0;
   localparam logic [2:0]  IDX_R1 = 3'h1;
   localparam logic [2:0]  IDX_R2 = 3'h2;
   localparam logic [2:0]  IDX_R3 = 3'h3;
   localparam logic [2:0]  IDX_R4 = 3'h4;
   localparam logic [2:0]  IDX_R5 = 3'h5;
   localparam int          OPND_NUM = 6;

   // Status register fields and reset values
   localparam int          ERR_BIT    = 7;
   localparam int          OVF_BIT    = 6;
   localparam logic [7:0]  STATUS_RST = 8'h00;
   localparam logic [7:0]  OPND_RST   = 8'h00;
   localparam logic [31:0] RDATA_RST  = 32'h0000_0000;

   // Calculation times in system clock periods
   localparam int          DIV32_CYCLES = 17;
   localparam int          DIV16_CYCLES = 9;
   localparam int          MUL_CYCLES   = 11;

   localparam logic [31:0] MUL_LIMIT = 32'h0000_FFFF;

   // Result registers loaded per operation
   localparam logic [5:0]  RES_EN_DIV32 = 6'h3F;
   localparam logic [5:0]  RES_EN_DIV16 = 6'h33;
   localparam logic [5:0]  RES_EN_MUL   = 6'h0F;

   localparam logic        HRESP_OKAY = 1'b0;

   typedef enum logic [1:0] {
      OP_DIV32 = 2'b00,
      OP_DIV16 = 2'b01,
      OP_MUL   = 2'b10
   } op_e;

   typedef enum logic [3:0] {
      SEQ_IDLE   = 4'b0000,
      SEQ_W0     = 4'b0001,
      SEQ_W01    = 4'b0010,
      SEQ_W04    = 4'b0011,
      SEQ_W012   = 4'b0100,
      SEQ_W014   = 4'b0101,
      SEQ_W041   = 4'b0110,
      SEQ_W0123  = 4'b0111,
      SEQ_W01234 = 4'b1000
   } seq_e;

endpackage

// file: common/muldiv_core_if.sv
`timescale 1ns/1ns
`default_nettype none
interface muldiv_core_if;
   logic                start;
   muldiv_pkg::op_e     op;
   logic [31:0]         dividend;
   logic [15:0]         divisor;
   logic                busy;
   logic                done;
   muldiv_pkg::op_e     run_op;
   logic                ovf;
   logic [31:0]         quot;
   logic [15:0]         rem;

   modport ctrl   (output start, op, dividend, divisor,
                   input  busy, done, run_op, ovf, quot, rem);
   modport engine (input  start, op, dividend, divisor,
                   output busy, done, run_op, ovf, quot, rem);
endinterface
`default_nettype wire

// file: core/muldiv_engine.sv
`timescale 1ns/1ns
`default_nettype none
module muldiv_engine #(
   parameter int CNT_W = 5
) (
   input  wire logic          mclk,
   input  wire logic          rst_n,
   muldiv_core_if.engine      core
);

   if ((1 << CNT_W) < muldiv_pkg::DIV32_CYCLES) begin : g_cnt_check
      $error("CNT_W too small for the longest operation");
   end

   muldiv_pkg::op_e   op_q;
   logic [31:0]       dvd_q;
   logic [15:0]       dvs_q;
   logic [CNT_W-1:0]  cnt_q;
   logic              busy_q;
   logic [CNT_W-1:0]  load;
   logic [31:0]       prod;
   logic              take;

   assign take = core.start && !busy_q;

   always_comb begin
      case (core.op)
         muldiv_pkg::OP_DIV32: load = CNT_W'(muldiv_pkg::DIV32_CYCLES - 1);
         muldiv_pkg::OP_DIV16: load = CNT_W'(muldiv_pkg::DIV16_CYCLES - 1);
         muldiv_pkg::OP_MUL:   load = CNT_W'(muldiv_pkg::MUL_CYCLES - 1);
         default:              load = '0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         cnt_q  <= '0;
      end else if (take) begin
         busy_q <= 1'b1;
         cnt_q  <= load;
      end else if (busy_q) begin
         if (cnt_q == '0) begin
            busy_q <= 1'b0;
         end else begin
            cnt_q <= cnt_q - CNT_W'(1);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         op_q  <= muldiv_pkg::OP_DIV32;
         dvd_q <= '0;
         dvs_q <= '0;
      end else if (take) begin
         op_q  <= core.op;
         dvd_q <= core.dividend;
         dvs_q <= core.divisor;
      end
   end

   assign prod = 32'(dvd_q[15:0]) * 32'(dvs_q);

   // Zero divisor yields zero quotient and remainder
   always_comb begin
      core.quot = '0;
      core.rem  = '0;
      case (op_q)
         muldiv_pkg::OP_MUL: core.quot = prod;
         muldiv_pkg::OP_DIV16: begin
            if (dvs_q != '0) begin
               core.quot = {16'h0000, dvd_q[15:0] / dvs_q};
               core.rem  = dvd_q[15:0] % dvs_q;
            end
         end
         default: begin
            if (dvs_q != '0) begin
               core.quot = dvd_q / {16'h0000, dvs_q};
               core.rem  = 16'(dvd_q % {16'h0000, dvs_q});
            end
         end
      endcase
   end

   assign core.ovf    = (op_q == muldiv_pkg::OP_MUL) ? (prod > muldiv_pkg::MUL_LIMIT)
                                                     : (dvs_q == '0);
   assign core.busy   = busy_q;
   assign core.done   = busy_q && (cnt_q == '0);
   assign core.run_op = op_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_finish;
      (core.done && busy_q) ##1 !busy_q;
   endsequence

   AST_DIV32_TIME:
   assert property ((take && core.op == muldiv_pkg::OP_DIV32) |-> ##17 s_finish)
      else $error("32/16 division not done after 17 cycles");
   AST_DIV16_TIME:
   assert property ((take && core.op == muldiv_pkg::OP_DIV16) |-> ##9 s_finish)
      else $error("16/16 division not done after 9 cycles");
   AST_MUL_TIME:
   assert property ((take && core.op == muldiv_pkg::OP_MUL) |-> ##11 s_finish)
      else $error("multiplication not done after 11 cycles");
   AST_OVF_ZERO_DIV:
   assert property ((take && core.op != muldiv_pkg::OP_MUL && core.divisor == '0)
                    |=> core.ovf throughout (busy_q [*2]))
      else $error("zero divisor did not flag overflow");

endmodule // muldiv_engine
`default_nettype wire

// file: sim/muldiv_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module muldiv_cpu_model (
   input  wire logic        mclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   // Single word transfer; each phase held until hready is sampled high
   task automatic xfer(input logic wr, input logic [7:0] adr, input logic [7:0] wd,
                       output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= {24'h0, adr};
      htrans <= 2'b10;
      hwrite <= wr;
      hwdata <= ~hwdata;
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      rd = hrdata;
   endtask
endmodule // muldiv_cpu_model
`default_nettype wire

// file: sim/tb_muldiv_unit.sv
`timescale 1ns/1ns
`default_nettype none
module tb_muldiv_unit;
   logic        mclk;
   logic        rst_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic [31:0] seed;
   int          n_errors;
   int          num_checks;

   localparam logic [7:0] STAT = muldiv_pkg::OFS_STATUS;

   muldiv_unit muldiv_unit_i (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
   muldiv_cpu_model muldiv_cpu_model_i (.mclk(mclk), .hready(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata));

   initial mclk = 1'b0;
   always #25 mclk = ~mclk;

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Result image: remainder in bytes 5:4, quotient or product in bytes 3:0
   function automatic logic [47:0] expect_res(muldiv_pkg::op_e op, logic [31:0] a,
                                              logic [15:0] b);
      if (op == muldiv_pkg::OP_MUL) return {16'h0, 32'(a[15:0]) * 32'(b)};
      if (b == 16'h0) return 48'h0;
      if (op == muldiv_pkg::OP_DIV16) return {a[15:0] % b, 16'h0, a[15:0] / b};
      return {16'(a % 32'(b)), a / 32'(b)};
   endfunction

   function automatic logic expect_ovf(muldiv_pkg::op_e op, logic [31:0] a, logic [15:0] b);
      if (op == muldiv_pkg::OP_MUL) return (32'(a[15:0]) * 32'(b)) > 32'h0000_FFFF;
      return b == 16'h0;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t read %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
      logic [31:0] rd;
      muldiv_cpu_model_i.xfer(1'b0, adr, 8'h00, rd);
      chk(rd, {24'h0, exp});
   endtask

   task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
      logic [31:0] rd;
      muldiv_cpu_model_i.xfer(1'b1, adr, wd, rd);
   endtask

   task automatic op_run(input muldiv_pkg::op_e op, input logic [31:0] a,
                         input logic [15:0] b, input logic early);
      logic [2:0]  wreg[$];
      logic [7:0]  wbyte[$];
      logic [2:0]  rreg[$];
      logic [47:0] r;
      int          n;
      logic [31:0] junk;
      logic        ov;
      r = expect_res(op, a, b);
      ov = expect_ovf(op, a, b);
      case (op)
         muldiv_pkg::OP_DIV32: begin
            wreg = '{0, 1, 2, 3, 4, 5};
            wbyte = '{a[7:0], a[15:8], a[23:16], a[31:24], b[7:0], b[15:8]};
            rreg = '{0, 1, 2, 3, 4, 5};
            n = muldiv_pkg::DIV32_CYCLES;
         end
         muldiv_pkg::OP_DIV16: begin
            wreg = '{0, 1, 4, 5};
            wbyte = '{a[7:0], a[15:8], b[7:0], b[15:8]};
            rreg = '{0, 1, 4, 5};
            n = muldiv_pkg::DIV16_CYCLES;
         end
         default: begin
            wreg = '{0, 4, 1, 5};
            wbyte = '{a[7:0], b[7:0], a[15:8], b[15:8]};
            rreg = '{0, 1, 2, 3};
            n = muldiv_pkg::MUL_CYCLES;
         end
      endcase
      foreach (wreg[i]) begin
         wr({3'h0, wreg[i], 2'b00}, wbyte[i]);
         seed = lfsr(seed);
         if (seed[0] && i < wreg.size() - 1) rd_chk(8'h1C, 8'h00);
      end
      if (early) begin
         repeat (n - 2) @(posedge mclk);
         muldiv_cpu_model_i.xfer(1'b0, 8'h00, 8'h00, junk);
         rd_chk(STAT, {1'b1, ov, 6'h00});
      end else begin
         repeat (n - 1) @(posedge mclk);
      end
      // Status first, then results in their fixed order
      rd_chk(STAT, {1'b0, ov, 6'h00});
      r = expect_res(op, a, b);
      foreach (rreg[i]) begin
         rd_chk({3'h0, rreg[i], 2'b00}, r[8 * rreg[i] +: 8]);
         seed = lfsr(seed);
         if (seed[1]) rd_chk(8'h1C, 8'h00);
      end
   endtask

   task automatic tally_and_finish();
      if (n_errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      tally_and_finish();
   end

   initial begin
      muldiv_pkg::op_e op;
      logic [31:0]     a;
      logic [15:0]     b;
      rst_n = 1'b0;
      n_errors = 0;
      num_checks = 0;
      seed = 32'h56f5;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rd_chk(muldiv_pkg::OFS_STATUS, muldiv_pkg::STATUS_RST);
      for (int i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         op = muldiv_pkg::op_e'(2'(seed % 3));
         a = lfsr(seed);
         b = 16'(lfsr(a));
         case (i)
            0: begin op = muldiv_pkg::OP_DIV32; a = 32'hFFFF_FFFF; b = 16'h0000; end
            1: begin op = muldiv_pkg::OP_MUL; a = 32'h0000_FFFF; b = 16'hFFFF; end
            2: begin op = muldiv_pkg::OP_MUL; a = 32'h0000_00FF; b = 16'h0101; end
            3: begin op = muldiv_pkg::OP_DIV16; a = 32'h0000_FFFF; b = 16'h0001; end
            4: begin op = muldiv_pkg::OP_DIV16; a = 32'h0000_1234; b = 16'h0000; end
            default: ;
         endcase
         seed = lfsr(a);
         op_run(op, a, b, seed[3]);
      end
      // Broken order, then a lone final write: nothing may start
      wr(8'h00, 8'h11);
      wr(8'h10, 8'h22);
      wr(8'h08, 8'h33);
      wr(8'h14, 8'h44);
      rd_chk(8'h00, 8'h11);
      rd_chk(8'h08, 8'h33);
      rd_chk(8'h10, 8'h22);
      wr(STAT, 8'hFF);
      // Overflow still shows the last operation's outcome
      rd_chk(STAT, {1'b0, expect_ovf(op, a, b), 6'h00});
      chk({31'h0, hresp}, {31'h0, muldiv_pkg::HRESP_OKAY});
      tally_and_finish();
   end
endmodule // tb_muldiv_unit
`default_nettype wire
